// file: adiw_master.sv
// Behavioural SPI master standing for the microcontroller die.
// Assumes SCK idles low; half sets the speed, prompt or slow.
`timescale 1ns/1ns
`default_nettype none
module adiw_master
(
  output logic spi_sck,
  output logic spi_ss_b,
  output logic spi_mosi,
  input wire logic spi_miso
);
  int half = 80;
  initial
  begin
    spi_sck = 1'b0;
    spi_ss_b = 1'b1;
    spi_mosi = 1'b0;
  end
  // A count other than 16 gives a frame the slave must drop
  task automatic xfer(input logic [15:0] tx, input int n,
                      output logic [15:0] rx);
    rx = 16'h0000;
    spi_ss_b = 1'b0;
    #(2 * half);
    for (int i = 15; i > 15 - n; i--)
    begin
      spi_sck = 1'b1;
      spi_mosi = tx[i];
      #(half) spi_sck = 1'b0;
      #(half - 1) rx = {rx[14:0], spi_miso};
      #1;
    end
    spi_ss_b = 1'b1;
    // Released line must not keep showing the last bit
    spi_mosi = ~spi_mosi;
    #(2 * half);
  endtask
endmodule
`default_nettype wire

// file: adiw_pkg.sv
// Package for the analog-die interrupt and wake-up block.
// Assumes one 50 MHz system clock and an SPI master on the other die.
package adiw_pkg;
  // ----------------------------------------------------------------
  // Register addresses (5-bit SPI address field)
  // ----------------------------------------------------------------
  localparam logic [4:0] ADIW_ADDR_MASK = 5'h04;
  localparam logic [4:0] ADIW_ADDR_FLAG = 5'h05;
  localparam logic [4:0] ADIW_ADDR_STAT = 5'h0c;
  // ----------------------------------------------------------------
  // Bit positions shared by mask and flag registers
  // ----------------------------------------------------------------
  localparam int ADIW_BIT_HALL = 6;
  localparam int ADIW_BIT_BUS = 5;
  localparam int ADIW_BIT_TEMP = 4;
  localparam int ADIW_BIT_LOWV = 3;
  localparam int ADIW_BIT_HIGHV = 2;
  localparam int ADIW_BIT_OC = 1;
  localparam int ADIW_BIT_WDOG = 0;
  localparam logic [7:0] ADIW_IRQ_BITS = 8'h7f;
  localparam logic [7:0] ADIW_RESET_VAL = 8'h00;
  // ----------------------------------------------------------------
  // SPI frame
  // ----------------------------------------------------------------
  localparam int ADIW_FRAME_BITS = 16;
  localparam logic [4:0] ADIW_CNT_DONE = 5'h10;
  localparam int ADIW_RW_POS = 15;
endpackage

// file: adiw_sync.sv
// Two-flop synchroniser, one per bit of a bus of asynchronous inputs.
// Assumes inputs change slower than the sampling clock.
`timescale 1ns/1ns
`default_nettype none
module adiw_sync
#(
  parameter int WIDTH = 1
)
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  // Stage1 is read by sync_out only, to keep metastability contained
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stage1 <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule
`default_nettype wire

// file: adiw_top.sv
// Interrupt and wake-up logic of the analog companion die, with its SPI
// slave. Assumes SCK, SS and all event inputs are asynchronous pins.
//
// What this block does
// R1 - Seven interrupt sources, each enabled separately through SPI writes
// R2 - Any reset clears every interrupt enable
// R3 - Supply below low threshold sets low-voltage flag, may interrupt
// R4 - Low-voltage event turns off bridge high sides and high-side driver
// R5 - Supply above high threshold sets high-voltage flag, may interrupt
// R6 - High-voltage event also turns off high sides and high-side driver
// R7 - In STOP the low, high voltage and temperature detectors are off
// R8 - Over-temperature sets high-temperature flag, may interrupt
// R9 - Bus falling edge interrupts when enabled and wakes from STOP
// R10 - Enabled Hall input high during cyclic check interrupts when Hall enable set; outside STOP any change of an enabled input interrupts instead
// R11 - In STOP the Hall check during watchdog cyclic wake may wake
// R12 - Over-current on bridge, high side or sensor supply may interrupt
// R13 - Four wake causes: bus edge, watchdog, Hall check, low-voltage reset
// R14 - Enabled wake cause in STOP wakes microcontroller and main regulator
// R15 - Errors and wakes other than low-voltage reset pull the open-drain interrupt line low
// R16 - Reset line is bidirectional open drain shared with the master
// R17 - Frames are two bytes: address and data in, status and data out
// R18 - Master drives slave select from a plain logic output
// R19 - MISO changes on rising SCK, MOSI sampled on falling SCK
// R20 - Only frames with exactly sixteen sample edges are accepted
// R21 - Write data is stored on the rising edge of slave select
// R22 - Writing one clears a flag, zero leaves it, reset clears it
// R23 - Interrupt line active while any flag meets its set enable
`timescale 1ns/1ns
`default_nettype none
module adiw_top
(
  input wire logic clk_sys,
  input wire logic rst_b,
  // SPI slave pins
  input wire logic spi_sck,
  input wire logic spi_ss_b,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  // Event sources (raw pins)
  input wire logic stop_mode,
  input wire logic supply_low,
  input wire logic supply_high,
  input wire logic temp_high,
  input wire logic bus_rx,
  input wire logic [2:0] hall_in,
  input wire logic [2:0] hall_enable,
  input wire logic awd_cyclic_check,
  input wire logic autonomous_watchdog_wake,
  input wire logic oc_bridge,
  input wire logic oc_high_side,
  input wire logic oc_switched_sensor_supply,
  input wire logic low_voltage_reset,
  input wire logic reset_req,
  // Reset and interrupt pins, open drain
  input wire logic die_reset_io_in,
  output logic die_reset_io_out,
  output logic die_reset_io_oe,
  output logic die_irq_out,
  output logic die_irq_oe,
  // Protection, wake and reset-seen outputs
  output logic high_side_off,
  output logic wake_mcu,
  output logic wake_main_regulator,
  output logic reset_seen
);
  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  localparam int NSYNC = 19;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] syn;
  // High-idle pins go in inverted, so a cleared synchroniser reads idle
  // and no false frame start, bus edge or reset follows reset release
  assign raw_in = {spi_sck, ~spi_ss_b, spi_mosi, stop_mode, supply_low,
                   supply_high, temp_high, ~bus_rx, hall_in, hall_enable,
                   awd_cyclic_check, autonomous_watchdog_wake,
                   oc_bridge | oc_high_side | oc_switched_sensor_supply,
                   low_voltage_reset, ~die_reset_io_in};

  adiw_sync #(.WIDTH(NSYNC)) u_sync
  (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .async_in(raw_in),
    .sync_out(syn)
  );

  wire s_sck = syn[18];
  wire s_ss_b = ~syn[17];
  wire s_mosi = syn[16];
  wire s_stop = syn[15];
  wire s_low = syn[14];
  wire s_high = syn[13];
  wire s_temp = syn[12];
  wire s_bus = ~syn[11];
  wire [2:0] s_hall = syn[10:8];
  wire [2:0] s_hall_en = syn[7:5];
  wire s_cyc = syn[4];
  wire s_wdog = syn[3];
  wire s_oc = syn[2];
  wire s_lvr = syn[1];
  wire s_rst_pin = ~syn[0];

  // ----------------------------------------------------------------
  // Edge detection on synchronised signals
  // ----------------------------------------------------------------
  logic sck_d;
  logic ss_d;
  logic bus_d;
  logic [2:0] hall_d;
  logic wdog_d;
  logic lvr_d;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sck_d <= 1'b0;
      ss_d <= 1'b1;
      bus_d <= 1'b1;
      hall_d <= 3'h0;
      wdog_d <= 1'b0;
      lvr_d <= 1'b0;
    end
    else
    begin
      sck_d <= s_sck;
      ss_d <= s_ss_b;
      bus_d <= s_bus;
      hall_d <= s_hall;
      wdog_d <= s_wdog;
      lvr_d <= s_lvr;
    end
  end

  wire sck_rise = s_sck & ~sck_d;
  wire sck_fall = ~s_sck & sck_d;
  wire ss_start = ~s_ss_b & ss_d;
  wire ss_end = s_ss_b & ~ss_d;
  wire in_frame = ~s_ss_b;
  wire bus_fall = ~s_bus & bus_d;
  wire wdog_rise = s_wdog & ~wdog_d;
  wire lvr_rise = s_lvr & ~lvr_d;

  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------
  // Voltage and temperature detectors are blanked in STOP
  wire det_on = ~s_stop; // see R7
  wire ev_low = s_low & det_on; // see R3
  wire ev_high = s_high & det_on; // see R5
  wire ev_temp = s_temp & det_on; // see R8
  // Run: any state change on an enabled input; Stop: high during check
  wire hall_run = |((s_hall ^ hall_d) & s_hall_en);
  wire hall_stop = s_cyc & (|(s_hall & s_hall_en)); // see R11
  wire ev_hall = s_stop ? hall_stop : hall_run; // see R10
  wire [7:0] ev_vec;
  assign ev_vec = {1'b0, ev_hall, bus_fall, ev_temp, ev_low, ev_high,
                   s_oc, wdog_rise}; // see R1, R9, R12

  // ----------------------------------------------------------------
  // SPI slave
  // ----------------------------------------------------------------
  logic [4:0] bit_cnt;
  logic [15:0] rx_shift;
  logic [15:0] tx_shift;
  logic [7:0] irq_mask;
  logic [7:0] irq_flag;

  function automatic logic [7:0] adiw_reg_read(input logic [4:0] addr,
                                               input logic [7:0] msk,
                                               input logic [7:0] flg,
                                               input logic [7:0] sts);
    begin
      case (addr)
        adiw_pkg::ADIW_ADDR_MASK: adiw_reg_read = msk;
        adiw_pkg::ADIW_ADDR_FLAG: adiw_reg_read = flg;
        adiw_pkg::ADIW_ADDR_STAT: adiw_reg_read = sts;
        default: adiw_reg_read = 8'h00;
      endcase
    end
  endfunction

  // Status byte: live condition levels
  wire [7:0] status_byte;
  assign status_byte = {1'b0, 1'b0, 1'b0, 1'b0, s_low, s_high, s_oc,
                        s_temp};
  // Address arrives in rx bits after eight samples
  wire [15:0] rx_next = {rx_shift[14:0], s_mosi};
  wire addr_done = sck_fall & (bit_cnt == 5'h07) & in_frame;
  wire [4:0] rx_addr = rx_next[6:2];
  wire [7:0] rd_byte = adiw_reg_read(rx_addr, irq_mask, irq_flag,
                                     status_byte);
  // Parity over R/W and address is only checked on writes
  wire parity_ok = ~^rx_shift[15:9];
  wire frame_ok = (bit_cnt == adiw_pkg::ADIW_CNT_DONE); // see R20
  wire do_write = ss_end & frame_ok & ~rx_shift[adiw_pkg::ADIW_RW_POS]
                  & parity_ok; // see R21
  wire [4:0] wr_addr = rx_shift[14:10];
  wire wr_mask = do_write & (wr_addr == adiw_pkg::ADIW_ADDR_MASK);
  wire wr_flag = do_write & (wr_addr == adiw_pkg::ADIW_ADDR_FLAG);
  wire [7:0] wr_data = rx_shift[7:0];

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bit_cnt <= 5'h00;
      rx_shift <= 16'h0000;
    end
    else if (ss_start)
    begin
      bit_cnt <= 5'h00;
    end
    else if (in_frame && sck_fall)
    begin
      // Count saturates at 31 so a long frame never wraps back to sixteen
      if (bit_cnt != 5'h1f)
        bit_cnt <= bit_cnt + 5'h01; // see R19, R20
      rx_shift <= rx_next;
    end
  end

  // MISO: first bit at the first rising SCK edge of the frame
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tx_shift <= 16'h0000;
      spi_miso <= 1'b0;
      spi_miso_oe <= 1'b0;
    end
    else
    begin
      spi_miso_oe <= in_frame;
      if (ss_start)
        tx_shift <= {status_byte, 8'h00}; // see R17
      else if (addr_done)
        tx_shift <= {rd_byte, 8'h00};
      else if (in_frame && sck_rise)
      begin
        spi_miso <= tx_shift[15]; // see R19
        tx_shift <= {tx_shift[14:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // Mask and flag registers
  // ----------------------------------------------------------------
  wire reset_in = ~s_rst_pin;
  wire [7:0] next_mask = wr_mask ? (wr_data & adiw_pkg::ADIW_IRQ_BITS)
                                 : irq_mask;
  wire [7:0] flag_clear = wr_flag ? wr_data : 8'h00;
  // Set wins over clear; a condition still present keeps its flag
  wire [7:0] next_flag = ((irq_flag & ~flag_clear) | ev_vec)
                         & adiw_pkg::ADIW_IRQ_BITS; // see R22

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irq_mask <= adiw_pkg::ADIW_RESET_VAL;
      irq_flag <= adiw_pkg::ADIW_RESET_VAL;
    end
    else if (reset_in)
    begin
      irq_mask <= adiw_pkg::ADIW_RESET_VAL; // see R2
      irq_flag <= adiw_pkg::ADIW_RESET_VAL; // see R22
    end
    else
    begin
      irq_mask <= next_mask; // see R1
      irq_flag <= next_flag;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  wire irq_any = |(irq_flag & irq_mask); // see R23
  wire wake_bus = bus_fall & irq_mask[adiw_pkg::ADIW_BIT_BUS];
  wire wake_wdog = wdog_rise & irq_mask[adiw_pkg::ADIW_BIT_WDOG];
  // Wake on the start of a Hall hit only, so one hit gives one pulse
  logic hall_stop_d;
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      hall_stop_d <= 1'b0;
    else
      hall_stop_d <= hall_stop;
  end
  wire wake_hall = hall_stop & ~hall_stop_d
                   & irq_mask[adiw_pkg::ADIW_BIT_HALL]; // see R11
  wire wake_lvr = lvr_rise & irq_mask[adiw_pkg::ADIW_BIT_LOWV];
  wire wake_any = s_stop & (wake_bus | wake_wdog | wake_hall | wake_lvr);

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      die_irq_out <= 1'b0;
      die_irq_oe <= 1'b0;
      die_reset_io_out <= 1'b0;
      die_reset_io_oe <= 1'b0;
      high_side_off <= 1'b0;
      wake_mcu <= 1'b0;
      wake_main_regulator <= 1'b0;
      reset_seen <= 1'b0;
    end
    else
    begin
      die_irq_out <= 1'b0;
      die_irq_oe <= irq_any; // see R15, R23
      die_reset_io_out <= 1'b0;
      die_reset_io_oe <= reset_req; // see R16
      reset_seen <= reset_in; // see R16
      high_side_off <= ev_low | ev_high; // see R4, R6
      wake_mcu <= wake_any; // see R9, R13, R14
      wake_main_regulator <= wake_any; // see R14
    end
  end
endmodule
`default_nettype wire

// file: adiw_top_properties.sv
// Port-level checker for the interrupt and wake-up block.
// Assumes binding to adiw_top; windows allow for 2-flop input sync.
`timescale 1ns/1ns
`default_nettype none
module adiw_top_properties
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic spi_ss_b,
  input wire logic spi_miso_oe,
  input wire logic stop_mode,
  input wire logic supply_low,
  input wire logic supply_high,
  input wire logic reset_req,
  input wire logic die_reset_io_in,
  input wire logic die_reset_io_out,
  input wire logic die_reset_io_oe,
  input wire logic die_irq_out,
  input wire logic die_irq_oe,
  input wire logic high_side_off,
  input wire logic wake_mcu,
  input wire logic wake_main_regulator,
  input wire logic reset_seen
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  // --------------------------------------------------------------
  // Sequences and properties
  // --------------------------------------------------------------
  sequence s_idle; spi_ss_b [*6]; endsequence
  sequence s_busy; !spi_ss_b [*6]; endsequence
  sequence s_fault;
    ((supply_low || supply_high) && !stop_mode && die_reset_io_in) [*8];
  endsequence
  property p_miso_off; s_idle |-> !spi_miso_oe; endproperty
  a_miso_off: assert property (p_miso_off)
    else $error("miso driven while deselected");
  property p_miso_on; s_busy |-> spi_miso_oe; endproperty
  a_miso_on: assert property (p_miso_on)
    else $error("miso not driven in frame");
  property p_hs_fault; s_fault |-> high_side_off; endproperty
  a_hs_fault: assert property (p_hs_fault)
    else $error("high sides left on in supply fault");
  property p_hs_stop; stop_mode [*8] |-> !high_side_off; endproperty
  a_hs_stop: assert property (p_hs_stop)
    else $error("supply detector active in stop");
  property p_od_pins; !die_irq_out && !die_reset_io_out; endproperty
  a_od_pins: assert property (p_od_pins)
    else $error("open-drain pin driven high");
  property p_rst_drive; reset_req [*4] |-> die_reset_io_oe; endproperty
  a_rst_drive: assert property (p_rst_drive)
    else $error("reset line not pulled");
  property p_seen; !die_reset_io_in [*4] |-> reset_seen; endproperty
  a_seen: assert property (p_seen)
    else $error("low reset line not seen");
  property p_irq_clr; !die_reset_io_in [*6] |-> !die_irq_oe; endproperty
  a_irq_clr: assert property (p_irq_clr)
    else $error("interrupt kept through reset");
  property p_wake_pair; wake_mcu == wake_main_regulator; endproperty
  a_wake_pair: assert property (p_wake_pair)
    else $error("wake outputs differ");
  property p_wake_pulse; wake_mcu |=> !wake_mcu; endproperty
  a_wake_pulse: assert property (p_wake_pulse)
    else $error("wake pulse too long");
endmodule
`default_nettype wire

// file: adiw_top_tb.sv
// Self-checking bench for adiw_top with a behavioural SPI master.
// Assumes adiw_master and the property checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module adiw_top_tb;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic stop_mode = 1'b0;
  logic awd_cyclic_check = 1'b0;
  logic reset_req = 1'b0;
  logic mcu_rst = 1'b0;
  logic [7:0] ev = 8'h00;
  logic [2:0] oc3 = 3'h0;
  logic [2:0] hall_en = 3'h7;
  logic [15:0] rx;
  logic [7:0] m;
  int bad_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int wake_n = 0;
  int seed = 24691;
  int k;
  int wsrc[5] = '{5, 0, 6, 7, 5};
  int wbit[5] = '{5, 0, 6, 3, 5};
  wire logic spi_sck, spi_ss_b, spi_mosi, spi_miso, spi_miso_oe;
  wire logic die_reset_io_oe, die_irq_oe, high_side_off;
  wire logic wake_mcu, wake_main_regulator, reset_seen;
  // Pull-up line, pulled low by either die
  wire logic die_reset_io_in = ~(die_reset_io_oe | mcu_rst);
  always #10 clk_sys = ~clk_sys;
  adiw_master u_mst (.spi_sck, .spi_ss_b, .spi_mosi, .spi_miso);
  adiw_top dut
  (
    .clk_sys, .rst_b, .spi_sck, .spi_ss_b, .spi_mosi, .spi_miso,
    .spi_miso_oe, .stop_mode, .supply_low(ev[3]), .supply_high(ev[2]),
    .temp_high(ev[4]), .bus_rx(~ev[5]), .hall_in({2'b00, ev[6]}),
    .hall_enable(hall_en), .awd_cyclic_check,
    .autonomous_watchdog_wake(ev[0]), .oc_bridge(oc3[0]),
    .oc_high_side(oc3[1]), .oc_switched_sensor_supply(oc3[2]),
    .low_voltage_reset(ev[7]), .reset_req, .die_reset_io_in,
    .die_reset_io_out(), .die_reset_io_oe, .die_irq_out(), .die_irq_oe,
    .high_side_off, .wake_mcu, .wake_main_regulator, .reset_seen
  );
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (wake_mcu === 1'b1)
      wake_n <= wake_n + 1;
    if (cyc == 40000)
    begin
      bad_count++;
      tally_and_finish;
    end
  end
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] frm(input logic rw,
                                      input logic [4:0] a,
                                      input logic [7:0] d);
    return {rw, a, ^{rw, a}, 1'b0, d};
  endfunction
  task automatic rd(input logic [4:0] a);
    u_mst.xfer(frm(1'b1, a, 8'h00), 16, rx);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    u_mst.xfer(frm(1'b0, a, d), 16, rx);
    tick(4);
  endtask
  task automatic fire(input int i);
    ev[i] = 1'b1;
    if (i == 1)
      oc3 = 3'h1 << ($unsigned($random(seed)) % 3);
    tick(6);
    if (i == 2 || i == 3)
      chk(high_side_off, !stop_mode);
    ev = 8'h00;
    oc3 = 3'h0;
    tick(8);
  endtask
  task automatic tally_and_finish;
    $display("bad_count %0d tests_run %0d", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    tick(16);
    rst_b = 1'b1;
    tick(6);
    rd(adiw_pkg::ADIW_ADDR_MASK);
    chk(rx[7:0], 8'h00);
    for (int j = 0; j < 8; j++)
    begin
      {ev[4:2], oc3} = 6'($random(seed));
      m = 8'($random(seed));
      u_mst.half = (j == 3) ? 200 : 80;
      tick(8);
      wr(adiw_pkg::ADIW_ADDR_MASK, m);
      rd(adiw_pkg::ADIW_ADDR_MASK);
      chk(rx, {4'h0, ev[3:2], |oc3, ev[4],
               m & adiw_pkg::ADIW_IRQ_BITS});
    end
    ev = 8'h00;
    oc3 = 3'h0;
    tick(8);
    wr(adiw_pkg::ADIW_ADDR_MASK, 8'h7f);
    u_mst.xfer(frm(1'b0, adiw_pkg::ADIW_ADDR_MASK, 8'h00) ^ 16'h0200, 16, rx);
    u_mst.xfer(frm(1'b0, adiw_pkg::ADIW_ADDR_MASK, 8'h00), 15, rx);
    rd(adiw_pkg::ADIW_ADDR_MASK);
    chk(rx[7:0], 8'h7f);
    wr(adiw_pkg::ADIW_ADDR_FLAG, 8'h7f);
    for (int i = 0; i < 7; i++)
    begin
      wr(adiw_pkg::ADIW_ADDR_MASK, 8'h01 << i);
      fire(i);
      chk(die_irq_oe, 1'b1);
      rd(adiw_pkg::ADIW_ADDR_FLAG);
      chk(rx[7:0], 8'h01 << i);
      wr(adiw_pkg::ADIW_ADDR_FLAG, 8'h00);
      chk(die_irq_oe, 1'b1);
      wr(adiw_pkg::ADIW_ADDR_MASK, 8'h7f ^ (8'h01 << i));
      chk(die_irq_oe, 1'b0);
      wr(adiw_pkg::ADIW_ADDR_FLAG, 8'h01 << i);
      rd(adiw_pkg::ADIW_ADDR_FLAG);
      chk(rx[7:0], 8'h00);
    end
    hall_en = 3'h6;
    fire(6);
    rd(adiw_pkg::ADIW_ADDR_FLAG);
    chk(rx[7:0], 8'h00);
    hall_en = 3'h7;
    stop_mode = 1'b1;
    awd_cyclic_check = 1'b1;
    for (int i = 2; i < 5; i++)
      fire(i);
    rd(adiw_pkg::ADIW_ADDR_FLAG);
    chk(rx[7:0], 8'h00);
    for (int i = 0; i < 5; i++)
    begin
      k = wake_n;
      wr(adiw_pkg::ADIW_ADDR_MASK, (i == 4) ? 8'h00 : 8'h01 << wbit[i]);
      fire(wsrc[i]);
      chk(16'(wake_n - k), (i == 4) ? 16'h0000 : 16'h0001);
    end
    stop_mode = 1'b0;
    awd_cyclic_check = 1'b0;
    tick(4);
    wr(adiw_pkg::ADIW_ADDR_FLAG, 8'h7f);
    for (int j = 0; j < 2; j++)
    begin
      wr(adiw_pkg::ADIW_ADDR_MASK, 8'h7f);
      fire(2);
      chk(die_irq_oe, 1'b1);
      reset_req = (j == 0);
      mcu_rst = (j == 1);
      tick(8);
      chk(reset_seen, 1'b1);
      reset_req = 1'b0;
      mcu_rst = 1'b0;
      tick(8);
      rd(adiw_pkg::ADIW_ADDR_MASK);
      chk(rx[7:0], 8'h00);
    end
    tally_and_finish;
  end
endmodule
bind adiw_top adiw_top_properties u_props
(
  .clk_sys, .rst_b, .spi_ss_b, .spi_miso_oe, .stop_mode, .supply_low,
  .supply_high, .reset_req, .die_reset_io_in, .die_reset_io_out,
  .die_reset_io_oe, .die_irq_out, .die_irq_oe, .high_side_off,
  .wake_mcu, .wake_main_regulator, .reset_seen
);
`default_nettype wire
